/* logic/sed_device.sv */
// EEPROM end: instruction decoder, status register and array
// How it works
// - Falling chip select starts a new instruction
// - Opcode is eight bits, MSB first
// - Unknown opcode: ignore clocks until reselected
// - 0000X110 sets write enable latch only
// - 0000X100 clears write enable latch only
// - 0000X101 streams status byte repeatedly
// - 0000X001 captures status byte, clocks 9-16
// - 1K/2K read 011, write 010, 8-bit address
// - 4K takes address bit eight from opcode
// - Read outputs bytes from clock 17 onward
// - Protect bits return to zero on reset
// - Protected area blocks memory writes
// - Write protect pin blocks protect-bit update
// - Latch is status bit 1, set only by set
// - Latch clear rejects memory and status writes
// - Latch clears on reset, clear, write end, pin
// - Status bit 0 shows write in progress
// - Latch set acts only at clock eight
// - Latch clear acts only at clock eight
// - Array delivered FFh, protect bits zero
// - Status bits 7-4 read one, unwritable
// - Protect code maps to upper fraction
`timescale 1ns/10ps
module sed_device
  import sed_pkg::*;
#(
  parameter int VARIANT = VARIANT_4K,
  parameter int WRITE_CNT = WRITE_CYCLES
)(
  input wire logic CLK_SYS, // System clock
  input wire logic RESET_N, // Async reset, low active
  sed_link_if.device LINK, // Serial link
  output logic BUSY, // Internal write running
  output logic WRITE_ENABLE_LATCH // Write enable latch
);
  // Two-flop synchronisers for the pins
  logic [3:0] s1_ff, s2_ff;
  logic sck_d_ff, cs_d_ff;
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      // Idle pin levels, so no false clock edge follows reset
      s1_ff <= 4'h9;
      s2_ff <= 4'h9;
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end
    else
    begin
      s1_ff <= {LINK.cs_n, LINK.sck, LINK.mosi, LINK.wp_n};
      s2_ff <= s1_ff;
      sck_d_ff <= s2_ff[2];
      cs_d_ff <= s2_ff[3];
    end
  end
  logic cs_n, sck, mosi, wp_n, sck_rise, sck_fall, cs_fall, cs_rise;
  assign cs_n = s2_ff[3];
  assign sck = s2_ff[2];
  assign mosi = s2_ff[1];
  assign wp_n = s2_ff[0];
  assign sck_rise = sck & ~sck_d_ff & ~cs_n;
  assign sck_fall = ~sck & sck_d_ff & ~cs_n;
  assign cs_fall = ~cs_n & cs_d_ff;
  assign cs_rise = cs_n & ~cs_d_ff;

  // Protected region test for a write address
  function automatic logic in_protect(input logic [1:0] bp,
    input logic [ADDR_W-1:0] a);
    logic [1:0] top;
    top = (VARIANT == VARIANT_4K) ? a[8:7] :
      (VARIANT == VARIANT_2K) ? a[7:6] : a[6:5];
    unique case (bp)
      2'h0: in_protect = 1'b0;
      2'h1: in_protect = (top == 2'h3);
      2'h2: in_protect = top[1];
      2'h3: in_protect = 1'b1;
    endcase
  endfunction

  // Address masked to the variant's size
  function automatic logic [ADDR_W-1:0] fit(input logic [ADDR_W-1:0] a);
    fit = (VARIANT == VARIANT_4K) ? a :
      (VARIANT == VARIANT_2K) ? {1'b0, a[7:0]} : {2'b00, a[6:0]};
  endfunction

  logic [7:0] mem [MEM_DEPTH] = '{default: MEM_INIT};
  sed_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [7:0] sh_ff, op_ff, status_in_ff, page_ff [16];
  logic [ADDR_W-1:0] addr_ff;
  logic [PAGE_W:0] npage_ff;
  logic [1:0] bp_ff, bp_new_ff;
  logic wel_ff, busy_ff, is_status_write_cmd_ff, st_ok_ff;
  logic [WT_W-1:0] wt_ff;
  logic miso_ff, oe_ff;
  logic [7:0] status;
  logic [7:0] nxt_sh;
  assign status = {ST_UPPER_ONES, bp_ff, wel_ff, busy_ff};
  assign nxt_sh = {sh_ff[6:0], mosi};

  // Decoder: bit counting and command phases
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_ff <= SED_IDLE;
      cnt_ff <= '0;
      sh_ff <= 8'h00;
      op_ff <= 8'h00;
      addr_ff <= '0;
    end
    else if (cs_n)
      state_ff <= SED_IDLE;
    else if (cs_fall)
    begin
      state_ff <= SED_OPCODE;
      cnt_ff <= '0;
    end
    else if (sck_rise && state_ff != SED_IDLE && state_ff != SED_DESEL)
    begin
      cnt_ff <= (cnt_ff == 6'h3F) ? cnt_ff : cnt_ff + 6'h01;
      sh_ff <= nxt_sh;
      if (state_ff == SED_OPCODE && cnt_ff == CNT_OPCODE - 6'h01)
      begin
        op_ff <= nxt_sh;
        if (nxt_sh[7:4] != OP_UPPER)
          state_ff <= SED_DESEL;
        else
          unique case (nxt_sh[2:0])
            OP_LATCH_SET, OP_LATCH_CLEAR, OP_STATUS_READ,
            OP_STATUS_WRITE: state_ff <= SED_STREAM;
            OP_MEM_READ, OP_MEM_WRITE:
            begin
              state_ff <= SED_STREAM;
              // Keep the address of a running write intact
              if (!busy_ff)
                addr_ff <= {(VARIANT == VARIANT_4K) && nxt_sh[OP_A8_BIT],
                  8'h00};
            end
            default: state_ff <= SED_DESEL;
          endcase
        if (busy_ff && nxt_sh[2:0] != OP_STATUS_READ)
          state_ff <= SED_DESEL; // Only status read runs during a write
      end
      else if (state_ff == SED_STREAM && cnt_ff == CNT_ADDR - 6'h01
        && (op_ff[2:0] == OP_MEM_READ || op_ff[2:0] == OP_MEM_WRITE))
        addr_ff <= fit({addr_ff[8], nxt_sh});
      else if (state_ff == SED_STREAM && cnt_ff >= CNT_ADDR
        && cnt_ff[2:0] == 3'h7 && op_ff[2:0] == OP_MEM_READ)
        addr_ff <= fit(addr_ff + 9'h001);
    end
  end

  // Serial output on falling clock: status or memory bytes
  logic [2:0] bitn;
  assign bitn = 3'h7 - cnt_ff[2:0];
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      miso_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else if (cs_n || state_ff != SED_STREAM)
      oe_ff <= 1'b0;
    else if (sck_fall && cnt_ff >= CNT_OPCODE)
    begin
      if (op_ff[2:0] == OP_STATUS_READ)
      begin
        oe_ff <= 1'b1;
        miso_ff <= status[bitn];
      end
      else if (op_ff[2:0] == OP_MEM_READ && cnt_ff >= CNT_ADDR)
      begin
        oe_ff <= 1'b1;
        miso_ff <= mem[addr_ff][bitn];
      end
    end
  end
  assign LINK.miso = miso_ff;
  assign LINK.miso_oe = oe_ff;

  // Write data collection: status byte and page buffer
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      status_in_ff <= 8'h00;
      npage_ff <= '0;
      for (int i = 0; i < 16; i++)
        page_ff[i] <= 8'h00;
    end
    else if (cs_fall && !busy_ff) // A status poll must not empty the page
      npage_ff <= '0;
    else if (sck_rise && state_ff == SED_STREAM && cnt_ff[2:0] == 3'h7)
    begin
      if (op_ff[2:0] == OP_STATUS_WRITE && cnt_ff == CNT_ADDR - 6'h01)
        status_in_ff <= nxt_sh;
      if (op_ff[2:0] == OP_MEM_WRITE && cnt_ff >= CNT_ADDR)
      begin
        page_ff[4'(addr_ff[3:0] + npage_ff[3:0])] <= nxt_sh;
        npage_ff <= npage_ff[PAGE_W] ? npage_ff : npage_ff + 5'h01;
      end
    end
  end

  // Latch, protect bits and internal write timer
  logic ok_len, do_write;
  assign ok_len = (op_ff[2:0] == OP_STATUS_WRITE) ? (cnt_ff == CNT_ADDR)
    : (cnt_ff > CNT_ADDR && cnt_ff[2:0] == 3'h0);
  assign do_write = cs_rise && state_ff == SED_STREAM && wel_ff
    && wp_n && ok_len && (op_ff[2:0] == OP_STATUS_WRITE ||
    (op_ff[2:0] == OP_MEM_WRITE && !in_protect(bp_ff, addr_ff)));
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      wel_ff <= 1'b0;
      busy_ff <= 1'b0;
      wt_ff <= '0;
      is_status_write_cmd_ff <= 1'b0;
      bp_new_ff <= BP_INIT;
    end
    else if (busy_ff)
    begin
      if (wt_ff == WT_W'(WRITE_CNT - 1))
      begin
        busy_ff <= 1'b0;
        wel_ff <= 1'b0;
      end
      else
        wt_ff <= wt_ff + 1'b1;
      if (!wp_n)
        wel_ff <= 1'b0;
    end
    else if (!wp_n)
      wel_ff <= 1'b0;
    else if (cs_rise && state_ff == SED_STREAM && cnt_ff == CNT_OPCODE)
    begin
      if (op_ff[2:0] == OP_LATCH_SET)
        wel_ff <= 1'b1;
      else if (op_ff[2:0] == OP_LATCH_CLEAR)
        wel_ff <= 1'b0;
    end
    else if (do_write)
    begin
      busy_ff <= 1'b1;
      wt_ff <= '0;
      is_status_write_cmd_ff <= (op_ff[2:0] == OP_STATUS_WRITE);
      bp_new_ff <= status_in_ff[ST_BP_HI:ST_BP_LO];
    end
  end

  // Array and protect bits commit at the end of the write time
  logic commit;
  assign commit = busy_ff && wt_ff == WT_W'(WRITE_CNT - 1);
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      bp_ff <= BP_INIT;
    else if (commit && is_status_write_cmd_ff)
      bp_ff <= bp_new_ff;
  end
  // Array has no reset: contents survive like nonvolatile cells
  always_ff @(posedge CLK_SYS)
  begin
    if (commit && !is_status_write_cmd_ff)
      for (int i = 0; i < 16; i++)
        if (5'(i) < npage_ff || npage_ff[PAGE_W])
          mem[{addr_ff[8:4], 4'(addr_ff[3:0] + 4'(i))}] <= page_ff[
            4'(addr_ff[3:0] + 4'(i))];
  end

  // Flag outputs
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      BUSY <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
    end
    else
    begin
      BUSY <= busy_ff;
      WRITE_ENABLE_LATCH <= wel_ff;
    end
  end
endmodule // sed_device

/* logic/sed_link_if.sv */
// Serial link between master and EEPROM decoder
`timescale 1ns/10ps
interface sed_link_if;
  logic cs_n; // Chip select, low active
  logic sck; // Serial clock from master
  logic mosi; // Master to device data
  logic miso; // Device to master data
  logic miso_oe; // Device drives miso
  logic wp_n; // Write protect pin, low active
  modport device (input cs_n, input sck, input mosi, input wp_n,
    output miso, output miso_oe);
  modport master (output cs_n, output sck, output mosi, output wp_n,
    input miso, input miso_oe);
endinterface

/* logic/sed_master.sv */
// Master end: sends one instruction frame over the serial link
`timescale 1ns/10ps
module sed_master
  import sed_pkg::*;
(
  input wire logic CLK_SYS, // System clock
  input wire logic RESET_N, // Async reset, low active
  sed_link_if.master LINK, // Serial link
  input wire logic START, // Pulse: begin a frame
  input wire logic [5:0] NBITS, // Serial clocks in frame
  input wire logic [63:0] TX_DATA, // Bits to send, MSB first
  input wire logic WP_N_IN, // Write protect level to drive
  output logic BUSY, // Frame in progress
  output logic DONE, // Pulse: frame finished
  output logic [63:0] RX_DATA // Bits received, last in bit 0
);
  logic [3:0] div_ff;
  logic [5:0] left_ff;
  logic [63:0] tx_ff;
  logic cs_n_ff, sck_ff, mosi_ff, wp_ff;
  logic m1_ff, m2_ff;
  logic tick;
  assign tick = (div_ff == SCK_HALF - 4'h1);

  // Clock divider runs only inside a frame
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      div_ff <= 4'h0;
    else if (!BUSY || tick)
      div_ff <= 4'h0;
    else
      div_ff <= div_ff + 4'h1;
  end

  // Miso synchroniser
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      m1_ff <= 1'b0;
      m2_ff <= 1'b0;
    end
    else
    begin
      m1_ff <= LINK.miso;
      m2_ff <= m1_ff;
    end
  end

  // Frame sequencer: mode 0, data out on low phase, sampled on rise
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
      wp_ff <= 1'b1;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      left_ff <= 6'h00;
      tx_ff <= 64'h0;
      RX_DATA <= 64'h0;
    end
    else
    begin
      DONE <= 1'b0;
      wp_ff <= WP_N_IN;
      if (!BUSY && START)
      begin
        BUSY <= 1'b1;
        cs_n_ff <= 1'b0;
        left_ff <= NBITS;
        mosi_ff <= TX_DATA[63];
        tx_ff <= {TX_DATA[62:0], 1'b0};
      end
      else if (BUSY && tick)
      begin
        if (left_ff == 6'h00)
        begin
          cs_n_ff <= 1'b1;
          BUSY <= 1'b0;
          DONE <= 1'b1;
        end
        else if (!sck_ff)
        begin
          sck_ff <= 1'b1;
          RX_DATA <= {RX_DATA[62:0], m2_ff};
        end
        else
        begin
          sck_ff <= 1'b0;
          left_ff <= left_ff - 6'h01;
          mosi_ff <= tx_ff[63];
          tx_ff <= {tx_ff[62:0], 1'b0};
        end
      end
    end
  end
  assign LINK.cs_n = cs_n_ff;
  assign LINK.sck = sck_ff;
  assign LINK.mosi = mosi_ff;
  assign LINK.wp_n = wp_ff;
endmodule // sed_master

/* logic/sed_pkg.sv */
// Shared constants for the serial EEPROM instruction decoder link
package sed_pkg;
  // Opcode fields: upper nibble zero, bit 3 ignored or address bit eight
  localparam logic [3:0] OP_UPPER = 4'h0;
  localparam logic [2:0] OP_LATCH_SET = 3'h6;
  localparam logic [2:0] OP_LATCH_CLEAR = 3'h4;
  localparam logic [2:0] OP_STATUS_READ = 3'h5;
  localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
  localparam logic [2:0] OP_MEM_READ = 3'h3;
  localparam logic [2:0] OP_MEM_WRITE = 3'h2;
  localparam int OP_A8_BIT = 3;
  // Status field positions and fixed upper nibble
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam logic [3:0] ST_UPPER_ONES = 4'hF;
  // Array geometry and delivery state
  localparam int ADDR_W = 9;
  localparam int MEM_DEPTH = 512;
  localparam int PAGE_W = 4;
  localparam logic [7:0] MEM_INIT = 8'hFF;
  localparam logic [1:0] BP_INIT = 2'h0;
  // Variant select: 1 = 1K, 2 = 2K, 4 = 4K
  localparam int VARIANT_1K = 1;
  localparam int VARIANT_2K = 2;
  localparam int VARIANT_4K = 4;
  // Bit counter width and the clock counts that mark byte ends
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_OPCODE = 6'h08;
  localparam logic [5:0] CNT_ADDR = 6'h10;
  localparam logic [5:0] CNT_BYTE = 6'h08;
  // Internal write time in microseconds and in system cycles
  localparam int WRITE_TIME_US = 4000;
  localparam int SYS_MHZ = 125;
  localparam int WRITE_CYCLES = WRITE_TIME_US * SYS_MHZ;
  localparam int WT_W = 20;
  // Serial clock divider at the master: half period in system cycles
  localparam logic [3:0] SCK_HALF = 4'hA;
  typedef enum logic [2:0] {
    SED_IDLE = 3'b000,
    SED_OPCODE = 3'b001,
    SED_STREAM = 3'b010,
    SED_DONE = 3'b011,
    SED_DESEL = 3'b100
  } sed_state_t;
endpackage

/* testbench/sed_link_checker.sv */
// Concurrent checks on the serial link between the two ends
`timescale 1ns/10ps
module sed_link_checker #(
  parameter int WRITE_CNT = 600
)(
  input wire logic CLK_SYS, // System clock
  input wire logic RESET_N, // Async reset, low active
  input wire logic cs_n, // Chip select, low active
  input wire logic sck, // Serial clock
  input wire logic mosi, // Master data
  input wire logic miso, // Device data
  input wire logic miso_oe, // Device drives miso
  input wire logic wp_n, // Write protect, low active
  input wire logic BUSY, // Device write running
  input wire logic WRITE_ENABLE_LATCH // Device write enable latch
);
  int busy_len_ff;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // Length of the running internal write, for the write time check
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
      busy_len_ff <= 0;
    else
      busy_len_ff <= BUSY ? busy_len_ff + 1 : 0;
  // Deselect long enough for the output to be released
  sequence desel_s;
    cs_n [*5];
  endsequence
  sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("serial clock runs while deselected");
  mosi_hold_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("master data moved at the sampling edge");
  oe_release_a: assert property (desel_s |-> !miso_oe)
    else $error("device output left on while deselected");
  oe_select_a: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("device output enabled while deselected");
  miso_edge_a: assert property (miso_oe && $past(miso_oe) && $changed(miso)
    |-> !sck)
    else $error("device data changed while clock high");
  wel_rise_a: assert property ($rose(WRITE_ENABLE_LATCH) |-> cs_n && wp_n)
    else $error("latch set while selected or protected");
  busy_start_a: assert property ($rose(BUSY) |-> $past(WRITE_ENABLE_LATCH) && cs_n)
    else $error("write started without the latch");
  wp_clear_a: assert property (!wp_n [*6] |-> !WRITE_ENABLE_LATCH)
    else $error("latch kept while write protect low");
  busy_len_a: assert property ($fell(BUSY) |-> busy_len_ff >= WRITE_CNT - 1
    && busy_len_ff <= WRITE_CNT + 1)
    else $error("internal write length wrong");
  write_end_a: assert property ($fell(BUSY) |-> ##[0:2] !WRITE_ENABLE_LATCH)
    else $error("latch not cleared at write end");
endmodule // sed_link_checker

/* testbench/tb.sv */
// Self-checking bench: master and device joined over the link
`timescale 1ns/10ps
module tb;
  import sed_pkg::*;
  localparam int WCNT = 600;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic [5:0] nbits = 6'h00;
  logic [63:0] tx_data = 64'h0;
  logic wp_n_in = 1'b1;
  logic m_busy, m_done, dev_busy, dev_wel, exp_busy;
  logic [63:0] rx_data;
  int error_cnt = 0;
  int checks = 0;
  int seed = 31519;
  logic [7:0] mem [MEM_DEPTH];
  logic [1:0] bp = 2'h0;
  logic write_enable_latch = 1'b0;
  logic pend = 1'b0;
  logic [7:0] ops [6] = '{8'h0E, 8'h0E, 8'h04, 8'h0C, 8'h16, 8'h06};
  int ns [6] = '{9, 8, 7, 8, 8, 8};
  sed_link_if link ();
  always #4 clk_sys = ~clk_sys;
  sed_master sed_master_inst (.CLK_SYS(clk_sys), .RESET_N(reset_n),
    .LINK(link), .START(start), .NBITS(nbits), .TX_DATA(tx_data),
    .WP_N_IN(wp_n_in), .BUSY(m_busy), .DONE(m_done), .RX_DATA(rx_data));
  sed_device #(.VARIANT(VARIANT_4K), .WRITE_CNT(WCNT)) sed_device_inst (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(link), .BUSY(dev_busy),
    .WRITE_ENABLE_LATCH(dev_wel));
  sed_link_checker #(.WRITE_CNT(WCNT)) sed_link_checker_inst (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .cs_n(link.cs_n), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
    .wp_n(link.wp_n), .BUSY(dev_busy), .WRITE_ENABLE_LATCH(dev_wel));
  // Comparisons of bytes and of single flags
  task automatic cmp8(input string what, input logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp1(input string what, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask
  // Model status byte: upper nibble fixed ones, idle busy flag
  function automatic logic [7:0] st();
    return {ST_UPPER_ONES, bp, write_enable_latch, 1'b0};
  endfunction
  // Protected upper fraction of the 4K array
  function automatic logic prot(input logic [8:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a[8]) || (bp == 2'h1 && &a[8:7]);
  endfunction
  // One frame, then the reference model applies its effect
  task automatic frame(input int n, input logic [63:0] tx);
    int i;
    logic [7:0] op;
    logic [8:0] a;
    op = tx[63:56];
    a = {op[OP_A8_BIT], tx[55:48]};
    exp_busy = 1'b0;
    @(negedge clk_sys);
    nbits = n[5:0];
    tx_data = tx;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    cmp1("m_busy", 1'b1, m_busy);
    for (i = 0; i < 3000 && m_done !== 1'b1; i++)
      @(negedge clk_sys);
    if (m_done !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch frame_done expected 1 seen %b", m_done);
    end
    repeat (16) @(negedge clk_sys);
    if (op[7:4] == OP_UPPER && !pend)
      case (op[2:0])
        OP_LATCH_SET: if (n == 8 && wp_n_in) write_enable_latch = 1'b1;
        OP_LATCH_CLEAR: if (n == 8) write_enable_latch = 1'b0;
        OP_STATUS_WRITE: if (n == 16 && write_enable_latch && wp_n_in)
        begin
          bp = tx[51:50];
          {write_enable_latch, exp_busy} = 2'b01;
        end
        OP_MEM_WRITE: if (n >= 24 && n % 8 == 0 && write_enable_latch && wp_n_in && !prot(a))
        begin
          for (i = 0; i < (n - 16) / 8; i++)
            mem[{a[8:4], a[3:0] + i[3:0]}] = tx[47 - 8 * i -: 8];
          {write_enable_latch, exp_busy} = 2'b01;
        end
        default: ;
      endcase
    // A write in flight keeps busy up and the latch set until it ends
    pend = pend | exp_busy;
    cmp1("busy", pend, dev_busy);
    if (!pend)
      cmp1("wel", write_enable_latch, dev_wel);
  endtask
  // Bounded wait for the internal write to end
  task automatic wait_idle();
    for (int i = 0; i < 2000 && dev_busy !== 1'b0; i++)
      @(negedge clk_sys);
    if (dev_busy !== 1'b0)
    begin
      error_cnt++;
      $display("mismatch busy_end expected 0 seen %b", dev_busy);
    end
    pend = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    logic [8:0] a, ra;
    logic [7:0] d1, d2;
    for (int k = 0; k < MEM_DEPTH; k++)
      mem[k] = MEM_INIT;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    frame(24, {8'h05, 56'h0});
    cmp8("status", st(), rx_data[15:8]);
    cmp8("status_rep", st(), rx_data[7:0]);
    a = 9'($random(seed));
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    // Write refused without the latch
    frame(24, {4'h0, a[8], OP_MEM_WRITE, a[7:0], d1, 40'h0});
    $display("test status and refused write done");
    // Latch set and clear with right and wrong clock counts
    for (int k = 0; k < 6; k++)
      frame(ns[k], {ops[k], 56'h0});
    $display("test latch done");
    // Page write that wraps inside the page, status seen while busy
    a[3:0] = 4'hF;
    frame(32, {4'h0, a[8], OP_MEM_WRITE, a[7:0], d1, d2, 32'h0});
    frame(16, {8'h05, 56'h0});
    cmp8("status_busy", st() | 8'h03, rx_data[7:0]);
    wait_idle();
    cmp1("wel_end", 1'b0, dev_wel);
    for (int k = 0; k < 2; k++)
    begin
      ra = k ? {a[8:4], 4'h0} : a;
      frame(40, {4'h0, ra[8], OP_MEM_READ, ra[7:0], 48'h0});
      cmp8("read0", mem[ra], rx_data[23:16]);
      cmp8("read1", mem[9'(ra + 1)], rx_data[15:8]);
      cmp8("read2", mem[9'(ra + 2)], rx_data[7:0]);
    end
    $display("test memory done");
    // Quarter protection, then writes inside and outside it
    frame(8, {8'h06, 56'h0});
    frame(16, {8'h01, 8'h04, 48'h0});
    wait_idle();
    frame(16, {8'h05, 56'h0});
    cmp8("status_bp", st(), rx_data[7:0]);
    frame(8, {8'h06, 56'h0});
    frame(24, {8'h0A, 8'hF0, d1, 40'h0});
    frame(24, {8'h0A, 8'h00, d2, 40'h0});
    wait_idle();
    $display("test protect done");
    // Write protect pin clears the latch and blocks updates
    frame(8, {8'h06, 56'h0});
    wp_n_in = 1'b0;
    write_enable_latch = 1'b0;
    repeat (10) @(negedge clk_sys);
    cmp1("wel_wp", write_enable_latch, dev_wel);
    frame(8, {8'h06, 56'h0});
    frame(16, {8'h01, 8'h0C, 48'h0});
    wp_n_in = 1'b1;
    frame(16, {8'h05, 56'h0});
    cmp8("status_wp", st(), rx_data[7:0]);
    $display("test write protect done");
    close_out();
  end
  // Watchdog sized well beyond the expected run of about 9400 cycles
  initial
  begin
    #(8 * 90000);
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    close_out();
  end
endmodule // tb
